// >>> rtl/smc_regs.svh
// register offsets, field positions, reset values and timing constants (kHz clock, times in ms) of the settings menu
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ==========================================
// register byte offsets, and upper address nibbles of the zero and span trim blocks
`define SMC_CTRL 8'h00
`define SMC_STATUS 8'h04
`define SMC_HI_LIMIT 8'h08
`define SMC_LO_LIMIT 8'h0c
`define SMC_SLAVE_ADDR 8'h10
`define SMC_BAUD_SAVED 8'h14
`define SMC_BAUD_ACTIVE 8'h18
`define SMC_PARITY 8'h1c
`define SMC_ZERO_BASE 4'h2
`define SMC_SPAN_BASE 4'h3

// ==========================================
// control fields
`define SMC_CTRL_SERIAL 0
`define SMC_CTRL_OUTS_LO 1
`define SMC_CTRL_RESTART 3

// ==========================================
// value bounds, range limits in degrees times ten
`define SMC_HI_MAX 16'h0708
`define SMC_LO_MIN 16'h0000
`define SMC_ADDR_MIN 16'h0001
`define SMC_ADDR_MAX 16'h0063
`define SMC_BAUD_MIN 16'h0001
`define SMC_BAUD_MAX 16'h0007
`define SMC_PAR_MIN 16'h0001
`define SMC_PAR_MAX 16'h0003
`define SMC_TRIM_MAX 16'h0028

// ==========================================
// reset values
`define SMC_HI_RST 16'h0708
`define SMC_LO_RST 16'h0000
`define SMC_ADDR_RST 7'h01
`define SMC_BAUD_RST 3'h3
`define SMC_PAR_RST 2'h3
`define SMC_TRIM_RST 6'h14

// ==========================================
// timing
`define SMC_CLK_KHZ 40000
`define SMC_TIMEOUT_MS 10000
`define SMC_BLINK_MS 500

`endif

// >>> rtl/smc_pkg.sv
// types of the settings menu controller
package smc_pkg;

    typedef enum logic [1:0] {
        ST_DISPLAY,
        ST_SELECT,
        ST_INPUT,
        ST_OUTPUT
    } smc_state_e;

    typedef enum logic [1:0] {
        DRV_NORMAL,
        DRV_ZERO,
        DRV_SPAN
    } smc_drive_e;

    typedef struct packed {
        logic set_k;
        logic inc;
        logic dec;
        logic escape_key;
    } smc_keys_s;

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic press;
    } smc_sync_s;

    typedef logic [3:0][5:0] smc_trim_t;

    typedef struct packed {
        smc_state_e state;
        logic menu;
        logic [2:0] param;
        logic [15:0] edit;
        logic [28:0] idle;
        logic [24:0] blink_cnt;
        logic show;
        logic [15:0] hi;
        logic [15:0] lo;
        logic [6:0] addr;
        logic [2:0] baud_saved;
        logic [2:0] baud_act;
        logic [1:0] parity;
        logic serial_en;
        logic [1:0] out_cnt;
        smc_trim_t zero;
        smc_trim_t span;
        smc_trim_t zero_drv;
        smc_trim_t span_drv;
        smc_drive_e drive;
        logic [1:0] drive_chan;
        logic [15:0] disp_value;
        logic [3:0] disp_param;
        logic [15:0] rdata;
    } smc_top_s;

endpackage : smc_pkg

// >>> rtl/smc_key_sync.sv
// key pin synchroniser with press pulse
`timescale 1ns/1ps
module smc_key_sync
    import smc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic press_out
);

    smc_sync_s r_reg;
    smc_sync_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.meta = pin_in;
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
        r_next.press = r_reg.sync & ~r_reg.prev;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign press_out = r_reg.press;

endmodule : smc_key_sync

// >>> rtl/smc_menu.sv
// front-panel settings menu controller with register port
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "smc_regs.svh"
module smc_menu
    import smc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `SMC_TIMEOUT_MS * `SMC_CLK_KHZ,
    parameter int unsigned BLINK_CYC = `SMC_BLINK_MS * `SMC_CLK_KHZ
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic set_key_in,
    input wire logic increment_key_in,
    input wire logic decrement_key_in,
    input wire logic escape_key_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output logic [1:0] state_out,
    output logic [3:0] disp_param_out,
    output logic [15:0] disp_value_out,
    output logic show_out,
    output logic [15:0] range_hi_out,
    output logic [15:0] range_lo_out,
    output logic [6:0] slave_addr_out,
    output logic [2:0] baud_code_out,
    output logic [1:0] parity_out,
    output logic [1:0] drive_mode_out,
    output logic [1:0] drive_chan_out,
    output logic [23:0] zero_trim_out,
    output logic [23:0] span_trim_out
);

    localparam logic [28:0] IDLE_LAST = 29'(TIMEOUT_CYC - 1);
    localparam logic [24:0] BLINK_LAST = 25'(BLINK_CYC - 1);

    smc_top_s r_reg;
    smc_top_s r_next;
    smc_keys_s kp;
    logic any_key;

    // ==========================================
    // key inputs
    smc_key_sync u_set (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(set_key_in),
        .press_out(kp.set_k)
    );
    smc_key_sync u_inc (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(increment_key_in),
        .press_out(kp.inc)
    );
    smc_key_sync u_dec (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(decrement_key_in),
        .press_out(kp.dec)
    );
    smc_key_sync u_esc (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(escape_key_in),
        .press_out(kp.escape_key)
    );

    assign any_key = kp.set_k | kp.inc | kp.dec | kp.escape_key;

    // ==========================================
    // stored value of the selected parameter
    function automatic logic [15:0] load_val(input smc_top_s s);
        logic [15:0] v;
        v = '0;
        if (s.menu) begin
            v = {10'h000, s.param[0] ? s.span[s.param[2:1]] : s.zero[s.param[2:1]]};
        end else begin
            unique case (s.param)
                3'd0: v = s.hi;
                3'd1: v = s.lo;
                3'd2: v = {9'h000, s.addr};
                3'd3: v = {13'h0000, s.baud_saved};
                default: v = {14'h0000, s.parity};
            endcase
        end
        return v;
    endfunction : load_val

    // ==========================================
    // next state
    always_comb begin
        logic [15:0] lo_b;
        logic [15:0] hi_b;
        logic [2:0] nxt;
        r_next = r_reg;
        lo_b = '0;
        hi_b = `SMC_TRIM_MAX;
        nxt = r_reg.param + 3'd1;
        r_next.rdata = '0;
        r_next.idle = (r_reg.state == ST_DISPLAY || any_key) ? '0 : r_reg.idle + 29'd1;

        if (!r_reg.menu) begin
            unique case (r_reg.param)
                3'd0: begin
                    lo_b = r_reg.lo;
                    hi_b = `SMC_HI_MAX;
                end
                3'd1: begin
                    lo_b = `SMC_LO_MIN;
                    hi_b = r_reg.hi;
                end
                3'd2: begin
                    lo_b = `SMC_ADDR_MIN;
                    hi_b = `SMC_ADDR_MAX;
                end
                3'd3: begin
                    lo_b = `SMC_BAUD_MIN;
                    hi_b = `SMC_BAUD_MAX;
                end
                default: begin
                    lo_b = `SMC_PAR_MIN;
                    hi_b = `SMC_PAR_MAX;
                end
            endcase
        end

        unique case (r_reg.state)
            ST_DISPLAY: begin
                if (kp.set_k) begin
                    r_next.state = ST_SELECT;
                    r_next.menu = 1'b0;
                end
            end
            ST_SELECT: begin
                if (kp.escape_key) begin
                    r_next.state = ST_DISPLAY;
                end else if (kp.set_k) begin
                    r_next.param = '0;
                    r_next.state = r_reg.menu ? ST_OUTPUT : ST_INPUT;
                    r_next.edit = load_val(r_next);
                end else if (kp.inc && r_reg.out_cnt != 2'd0) begin
                    r_next.menu = 1'b1;
                end else if (kp.dec) begin
                    r_next.menu = 1'b0;
                end
            end
            ST_INPUT, ST_OUTPUT: begin
                if (kp.escape_key) begin
                    r_next.state = ST_SELECT;
                end else if (kp.set_k) begin
                    if (r_reg.menu) begin
                        if (r_reg.param[0]) begin
                            r_next.span[r_reg.param[2:1]] = r_reg.edit[5:0];
                        end else begin
                            r_next.zero[r_reg.param[2:1]] = r_reg.edit[5:0];
                        end
                        // two outputs wrap after four trims, four outputs by overflow
                        if (r_reg.out_cnt == 2'd1 && nxt == 3'd4) begin
                            nxt = '0;
                        end
                    end else begin
                        unique case (r_reg.param)
                            3'd0: r_next.hi = (r_reg.edit < lo_b) ? lo_b : r_reg.edit;
                            3'd1: r_next.lo = (r_reg.edit > hi_b) ? hi_b : r_reg.edit;
                            3'd2: r_next.addr = r_reg.edit[6:0];
                            3'd3: r_next.baud_saved = r_reg.edit[2:0];
                            default: r_next.parity = r_reg.edit[1:0];
                        endcase
                        if (nxt == 3'd5 || (nxt == 3'd2 && !r_reg.serial_en)) begin
                            nxt = '0;
                        end
                    end
                    r_next.param = nxt;
                    r_next.edit = load_val(r_next);
                end else if (kp.inc) begin
                    if (r_reg.edit < hi_b) begin
                        r_next.edit = r_reg.edit + 16'd1;
                    end
                end else if (kp.dec) begin
                    if (r_reg.edit > lo_b) begin
                        r_next.edit = r_reg.edit - 16'd1;
                    end
                end
            end
        endcase

        if (r_reg.state != ST_DISPLAY && !any_key && r_reg.idle == IDLE_LAST) begin
            r_next.state = ST_DISPLAY;
        end

        // register writes
        if (wr_in) begin
            unique case (addr_in)
                `SMC_CTRL: begin
                    r_next.serial_en = wdata_in[`SMC_CTRL_SERIAL];
                    r_next.out_cnt = wdata_in[`SMC_CTRL_OUTS_LO +: 2] == 2'd3 ? 2'd2
                        : wdata_in[`SMC_CTRL_OUTS_LO +: 2];
                    if (wdata_in[`SMC_CTRL_RESTART]) begin
                        r_next.baud_act = r_reg.baud_saved;
                    end
                end
                `SMC_HI_LIMIT: begin
                    if (wdata_in >= r_next.lo && wdata_in <= `SMC_HI_MAX) begin
                        r_next.hi = wdata_in;
                    end
                end
                `SMC_LO_LIMIT: begin
                    if (wdata_in <= r_next.hi) begin
                        r_next.lo = wdata_in;
                    end
                end
                `SMC_SLAVE_ADDR: begin
                    if (wdata_in >= `SMC_ADDR_MIN && wdata_in <= `SMC_ADDR_MAX) begin
                        r_next.addr = wdata_in[6:0];
                    end
                end
                `SMC_BAUD_SAVED: begin
                    if (wdata_in >= `SMC_BAUD_MIN && wdata_in <= `SMC_BAUD_MAX) begin
                        r_next.baud_saved = wdata_in[2:0];
                    end
                end
                `SMC_PARITY: begin
                    if (wdata_in >= `SMC_PAR_MIN && wdata_in <= `SMC_PAR_MAX) begin
                        r_next.parity = wdata_in[1:0];
                    end
                end
                default: begin
                    if (wdata_in <= `SMC_TRIM_MAX && addr_in[1:0] == 2'b00) begin
                        if (addr_in[7:4] == `SMC_ZERO_BASE) begin
                            r_next.zero[addr_in[3:2]] = wdata_in[5:0];
                        end else if (addr_in[7:4] == `SMC_SPAN_BASE) begin
                            r_next.span[addr_in[3:2]] = wdata_in[5:0];
                        end
                    end
                end
            endcase
        end

        // register reads, answer in the next cycle only
        if (rd_in) begin
            unique case (addr_in)
                `SMC_CTRL: r_next.rdata = {13'h0000, r_reg.out_cnt, r_reg.serial_en};
                `SMC_STATUS: r_next.rdata = {10'h000, r_reg.param, r_reg.menu, r_reg.state};
                `SMC_HI_LIMIT: r_next.rdata = r_reg.hi;
                `SMC_LO_LIMIT: r_next.rdata = r_reg.lo;
                `SMC_SLAVE_ADDR: r_next.rdata = {9'h000, r_reg.addr};
                `SMC_BAUD_SAVED: r_next.rdata = {13'h0000, r_reg.baud_saved};
                `SMC_BAUD_ACTIVE: r_next.rdata = {13'h0000, r_reg.baud_act};
                `SMC_PARITY: r_next.rdata = {14'h0000, r_reg.parity};
                default: begin
                    if (addr_in[1:0] == 2'b00 && addr_in[7:4] == `SMC_ZERO_BASE) begin
                        r_next.rdata = {10'h000, r_reg.zero[addr_in[3:2]]};
                    end else if (addr_in[1:0] == 2'b00 && addr_in[7:4] == `SMC_SPAN_BASE) begin
                        r_next.rdata = {10'h000, r_reg.span[addr_in[3:2]]};
                    end
                end
            endcase
        end

        // blink of label and value share one phase
        if (r_next.state == ST_INPUT || r_next.state == ST_OUTPUT) begin
            if (r_reg.blink_cnt == BLINK_LAST) begin
                r_next.blink_cnt = '0;
                r_next.show = ~r_reg.show;
            end else begin
                r_next.blink_cnt = r_reg.blink_cnt + 25'd1;
            end
        end else begin
            r_next.blink_cnt = '0;
            r_next.show = 1'b1;
        end

        // output drive follows the trim under edit
        r_next.zero_drv = r_next.zero;
        r_next.span_drv = r_next.span;
        r_next.drive = DRV_NORMAL;
        r_next.drive_chan = r_next.param[2:1];
        if (r_next.state == ST_OUTPUT) begin
            if (r_next.param[0]) begin
                r_next.drive = DRV_SPAN;
                r_next.span_drv[r_next.param[2:1]] = r_next.edit[5:0];
            end else begin
                r_next.drive = DRV_ZERO;
                r_next.zero_drv[r_next.param[2:1]] = r_next.edit[5:0];
            end
        end
        r_next.disp_param = {r_next.menu, r_next.param};
        unique case (r_next.state)
            ST_DISPLAY: r_next.disp_value = '0;
            ST_SELECT: r_next.disp_value = {15'h0000, r_next.menu};
            default: r_next.disp_value = r_next.edit;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_reg <= '0;
            r_reg.state <= ST_DISPLAY;
            r_reg.show <= 1'b1;
            r_reg.hi <= `SMC_HI_RST;
            r_reg.lo <= `SMC_LO_RST;
            r_reg.addr <= `SMC_ADDR_RST;
            r_reg.baud_saved <= `SMC_BAUD_RST;
            r_reg.baud_act <= `SMC_BAUD_RST;
            r_reg.parity <= `SMC_PAR_RST;
            r_reg.zero <= {4{`SMC_TRIM_RST}};
            r_reg.span <= {4{`SMC_TRIM_RST}};
            r_reg.zero_drv <= {4{`SMC_TRIM_RST}};
            r_reg.span_drv <= {4{`SMC_TRIM_RST}};
            r_reg.drive <= DRV_NORMAL;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================
    // outputs
    assign rdata_out = r_reg.rdata;
    assign state_out = r_reg.state;
    assign disp_param_out = r_reg.disp_param;
    assign disp_value_out = r_reg.disp_value;
    assign show_out = r_reg.show;
    assign range_hi_out = r_reg.hi;
    assign range_lo_out = r_reg.lo;
    assign slave_addr_out = r_reg.addr;
    assign baud_code_out = r_reg.baud_act;
    assign parity_out = r_reg.parity;
    assign drive_mode_out = r_reg.drive;
    assign drive_chan_out = r_reg.drive_chan;
    assign zero_trim_out = r_reg.zero_drv;
    assign span_trim_out = r_reg.span_drv;

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_set_in_display;
        r_reg.state == ST_DISPLAY && kp.set_k;
    endsequence

    sequence s_inc_at_top;
        r_reg.state == ST_INPUT && r_reg.param == 3'd0 && kp.inc && !kp.set_k && !kp.escape_key
            && r_reg.edit == `SMC_HI_MAX;
    endsequence

    chk_set_opens_menu: assert property (s_set_in_display |=> r_reg.state == ST_SELECT)
        else $error("set key did not open selection");
    chk_sel_forward: assert property (r_reg.state == ST_SELECT && kp.inc && !kp.set_k
        && !kp.escape_key && r_reg.out_cnt != 2'd0 |=> r_reg.menu)
        else $error("increment did not step menu forward");
    chk_esc_leaves: assert property (r_reg.state == ST_SELECT && kp.escape_key
        |=> r_reg.state == ST_DISPLAY)
        else $error("escape did not leave settings");
    chk_idle_exit: assert property (r_reg.state != ST_DISPLAY && !any_key
        && r_reg.idle == IDLE_LAST |=> r_reg.state == ST_DISPLAY)
        else $error("inactivity did not leave settings");
    chk_show_steady: assert property (r_reg.state inside {ST_DISPLAY, ST_SELECT}
        |-> r_reg.show)
        else $error("blink outside a parameter menu");
    chk_hi_limit: assert property (r_reg.hi <= `SMC_HI_MAX && r_reg.hi >= r_reg.lo)
        else $error("highest limit out of range");
    chk_lo_edit: assert property (r_reg.state == ST_INPUT && r_reg.param == 3'd1
        |-> r_reg.edit <= r_reg.hi)
        else $error("lowest limit edit above highest limit");
    chk_addr_range: assert property (r_reg.addr >= 7'd1 && r_reg.addr <= 7'd99)
        else $error("slave address out of range");
    chk_baud_restart: assert property ($changed(r_reg.baud_act) |-> $past(wr_in
        && addr_in == `SMC_CTRL && wdata_in[`SMC_CTRL_RESTART]))
        else $error("baud rate changed without restart");
    chk_parity_code: assert property (r_reg.parity != 2'd0)
        else $error("illegal parity code");
    chk_zero_point: assert property (r_reg.state == ST_OUTPUT && !r_reg.param[0]
        |-> r_reg.drive == DRV_ZERO && r_reg.drive_chan == r_reg.param[2:1])
        else $error("zero edit not at 4 mA point");
    chk_span_point: assert property (r_reg.state == ST_OUTPUT && r_reg.param[0]
        |-> r_reg.drive == DRV_SPAN && r_reg.edit <= `SMC_TRIM_MAX)
        else $error("span edit not at 20 mA point");
    chk_trim_follow: assert property (r_reg.state == ST_OUTPUT && r_reg.param[0]
        |-> r_reg.span_drv[r_reg.param[2:1]] == r_reg.edit[5:0])
        else $error("span drive does not follow edit");
    chk_inc_saturate: assert property (s_inc_at_top |=> r_reg.edit == `SMC_HI_MAX)
        else $error("increment wrapped past the bound");

endmodule : smc_menu

// >>> tb/smc_keypad.sv
// behavioural front-panel keys pressed by a person
`timescale 1ns/1ps
module smc_keypad (
    input wire logic clk_in,
    input wire logic [3:0] req_in,
    output logic [3:0] pins_out,
    output logic busy_out
);
    logic [3:0] pins_reg = 4'h0;
    logic [3:0] cnt_reg = 4'h0;
    // hold four cycles, then release four cycles before the next press
    always @(posedge clk_in) begin
        if (req_in != 4'h0 && cnt_reg == 4'h0) begin
            pins_reg <= req_in;
            cnt_reg <= 4'h8;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h5) begin
                pins_reg <= 4'h0;
            end
        end
    end
    assign pins_out = pins_reg;
    assign busy_out = (cnt_reg != 4'h0);
endmodule : smc_keypad

// >>> tb/smc_menu_tb_top.sv
// self-checking bench of the settings menu controller
`timescale 1ns/1ps
module smc_menu_tb_top;
    import smc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] req = 4'h0;
    logic [3:0] pins;
    logic busy;
    logic [15:0] rdata_out, disp_value_out, range_hi_out, range_lo_out;
    logic [1:0] state_out, parity_out, drive_mode_out, drive_chan_out;
    logic [3:0] disp_param_out;
    logic show_out, saw0, saw1;
    logic [6:0] slave_addr_out;
    logic [2:0] baud_code_out;
    logic [23:0] zero_trim_out, span_trim_out;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    always #12.5 clk_in = ~clk_in;
    smc_keypad keys_u (.clk_in(clk_in), .req_in(req), .pins_out(pins), .busy_out(busy));
    smc_menu #(.TIMEOUT_CYC(200), .BLINK_CYC(8)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .set_key_in(pins[3]), .increment_key_in(pins[2]),
        .decrement_key_in(pins[1]), .escape_key_in(pins[0]), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .state_out(state_out), .disp_param_out(disp_param_out),
        .disp_value_out(disp_value_out), .show_out(show_out), .range_hi_out(range_hi_out),
        .range_lo_out(range_lo_out), .slave_addr_out(slave_addr_out),
        .baud_code_out(baud_code_out), .parity_out(parity_out),
        .drive_mode_out(drive_mode_out), .drive_chan_out(drive_chan_out),
        .zero_trim_out(zero_trim_out), .span_trim_out(span_trim_out));
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask : rd
    // one press and release, then let the menu settle
    task automatic press(input logic [3:0] k);
        @(posedge clk_in);
        req <= k;
        @(posedge clk_in);
        req <= 4'h0;
        repeat (12) @(posedge clk_in);
        while (busy) @(posedge clk_in);
        #1;
    endtask : press
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(8'h08, 16'h0708);
        rd(8'h0c, 16'h0000);
        rd(8'h40, 16'h0000);
        wr(8'h08, 16'h0709);
        rd(8'h08, 16'h0708);
        wr(8'h08, 16'h0640);
        chk(range_hi_out, 16'h0640);
        wr(8'h0c, 16'h0641);
        rd(8'h0c, 16'h0000);
        wr(8'h10, 16'h0000);
        wr(8'h10, 16'h0064);
        rd(8'h10, 16'h0001);
        wr(8'h10, 16'h0063);
        chk(16'(slave_addr_out), 16'h0063);
        for (int p = 1; p <= 3; p++) begin
            wr(8'h1c, 16'(p));
            chk(16'(parity_out), 16'(p));
        end
        wr(8'h14, 16'h0008);
        wr(8'h14, 16'h0005);
        rd(8'h14, 16'h0005);
        chk(16'(baud_code_out), 16'h0003);
        wr(8'h00, 16'h0008);
        chk(16'(baud_code_out), 16'h0005);
        rd(8'h18, 16'h0005);
        wr(8'h08, 16'h0708);
        press(4'h8);
        chk(16'(state_out), 16'h0001);
        press(4'h8);
        chk(16'(state_out), 16'h0002);
        chk(disp_value_out, 16'h0708);
        saw0 = 1'b0;
        saw1 = 1'b0;
        repeat (20) begin
            @(posedge clk_in);
            #1;
            saw0 |= ~show_out;
            saw1 |= show_out;
        end
        chk(16'({saw0, saw1}), 16'h0003);
        press(4'h4);
        chk(disp_value_out, 16'h0708);
        press(4'h2);
        press(4'h8);
        chk(range_hi_out, 16'h0707);
        chk(16'(disp_param_out), 16'h0001);
        press(4'h2);
        chk(disp_value_out, 16'h0000);
        press(4'h1);
        chk(16'(state_out), 16'h0001);
        press(4'h1);
        chk(16'(state_out), 16'h0000);
        wr(8'h00, 16'h0003);
        press(4'h8);
        press(4'h4);
        chk(disp_value_out, 16'h0001);
        press(4'h2);
        chk(disp_value_out, 16'h0000);
        press(4'h8);
        press(4'h8);
        press(4'h4);
        press(4'h8);
        chk(range_lo_out, 16'h0001);
        chk(disp_value_out, 16'h0063);
        press(4'h4);
        chk(disp_value_out, 16'h0063);
        press(4'h1);
        chk(16'(state_out), 16'h0001);
        press(4'h4);
        press(4'h8);
        chk(16'(state_out), 16'h0003);
        chk(16'(drive_mode_out), 16'h0001);
        press(4'h4);
        chk(16'(zero_trim_out[5:0]), 16'h0015);
        press(4'h8);
        rd(8'h20, 16'h0015);
        chk(16'(drive_mode_out), 16'h0002);
        chk(16'(drive_chan_out), 16'h0000);
        press(4'h4);
        chk(16'(span_trim_out[5:0]), 16'h0015);
        press(4'h8);
        chk(16'(drive_chan_out), 16'h0001);
        chk(16'(drive_mode_out), 16'h0001);
        repeat (220) @(posedge clk_in);
        #1;
        chk(16'(state_out), 16'h0000);
        chk(16'(drive_mode_out), 16'h0000);
        chk(16'(span_trim_out[5:0]), 16'h0015);
        wrap_up();
    end
endmodule : smc_menu_tb_top
